// ==== common/cio_defs.svh ====
// register map, reset values and timing counts for the io port block
`ifndef CIO_DEFS_SVH
`define CIO_DEFS_SVH

`define CIO_ADDR_P0_LATCH   8'h80
`define CIO_ADDR_P1_LATCH   8'h90
`define CIO_ADDR_P1_CFG_A   8'h91
`define CIO_ADDR_P1_CFG_B   8'h92
`define CIO_ADDR_P0_CFG_A   8'h93
`define CIO_ADDR_P0_CFG_B   8'h94

`define CIO_RST_P0_LATCH    4'hf
`define CIO_RST_P1_LATCH    8'hff
`define CIO_RST_CFG4        4'h0
`define CIO_RST_CFG8        8'h00
`define CIO_P0_RSVD_RD      4'hf
`define CIO_CFG_RSVD_RD     4'h0

`define CIO_BOOST_CYCLES    2
`define CIO_BOOST_CNT_W     2

`endif

// ==== common/cio_pkg.sv ====
// types shared by the io port block
package cio_pkg;
    typedef enum logic [1:0] {
        CIO_MODE_QUASI = 2'b00,
        CIO_MODE_PUSH  = 2'b01,
        CIO_MODE_INPUT = 2'b10,
        CIO_MODE_OPEN  = 2'b11
    } cio_mode_t;
endpackage

// ==== logic/cio_sync.sv ====
// two flip-flop synchroniser for a bank of pin levels
`timescale 1ns/1ps
module cio_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    initial begin
        if (WIDTH < 1) begin
            $error("cio_sync width must be at least one");
        end
    end

    // first stage feeds only the second
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// ==== logic/cio_pin.sv ====
// pull control for one pin from latch, sensed level and mode
`timescale 1ns/1ps
`include "cio_defs.svh"
module cio_pin (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic latch_i,
    input  wire logic sel_a_i,
    input  wire logic sel_b_i,
    input  wire logic pin_sync_i,
    output logic      pu_vweak_o,
    output logic      pu_weak_o,
    output logic      pu_strong_o,
    output logic      pd_o
);
    logic                        latch_q;
    logic [`CIO_BOOST_CNT_W-1:0] boost_q;
    logic [`CIO_BOOST_CNT_W-1:0] boost_d;
    cio_pkg::cio_mode_t          mode;
    wire  quasi = (mode == cio_pkg::CIO_MODE_QUASI);
    wire  push  = (mode == cio_pkg::CIO_MODE_PUSH);
    wire  rise  = latch_i & ~latch_q;

    assign mode = cio_pkg::cio_mode_t'({sel_a_i, sel_b_i});

    // two cycle boost on latch rise
    assign boost_d = (quasi && rise)
        ? `CIO_BOOST_CNT_W'(`CIO_BOOST_CYCLES)
        : (boost_q != '0 ? boost_q - 1'b1 : boost_q);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_q <= 1'b1;
            boost_q <= '0;
        end else begin
            latch_q <= latch_i;
            boost_q <= boost_d;
        end
    end

    // very weak pull-up on latch one
    assign pu_vweak_o = quasi & latch_i;
    // weak pull-up needs pin high too
    assign pu_weak_o  = quasi & latch_i & pin_sync_i;
    assign pu_strong_o = (push & latch_i) | (quasi & latch_i & boost_q != '0);
    assign pd_o = ~latch_i & (mode != cio_pkg::CIO_MODE_INPUT);

    a_boost_len: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        quasi && rise && latch_i ##1 (quasi && latch_i) [*2]
        |-> $past(pu_strong_o) && pu_strong_o ##1 boost_q == '0)
        else $error("boost length wrong");
endmodule

// ==== logic/cio_port.sv ====
// Function
// - four port 0 pins, eight port 1
// - each pin mode set independently
// - sel bits pick quasi, push, input, open
// - quasi drives low strong, high weak
// - quasi very weak pull-up on latch one
// - quasi weak pull-up needs pin high
// - quasi latch rise gives two-cycle strong pull-up
// - push-pull holds strong pull-up on one
// - input-only keeps all pulls off
// - open-drain pulls down only on zero
// - port 0 latch reset low nibble ones
// - port 0 mode regs reset zero
// - port 1 latch changes only by cpu
// - port 1 config a resets zero
// - port 1 config b at 0x92
`timescale 1ns/1ps
`include "cio_defs.svh"
module cio_port #(
    parameter int P0_PINS = 4,
    parameter int P1_PINS = 8
) (
    input  wire logic               mclk_i,
    input  wire logic               rst_i,
    input  wire logic [7:0]         sfr_addr_i,
    input  wire logic [7:0]         sfr_wdata_i,
    input  wire logic               sfr_wr_i,
    input  wire logic               sfr_rd_i,
    output logic      [7:0]         sfr_rdata_o,
    output logic                    sfr_hit_o,
    input  wire logic [P0_PINS-1:0] p0_pin_i,
    input  wire logic [P1_PINS-1:0] p1_pin_i,
    output logic      [P0_PINS-1:0] p0_pu_vweak_o,
    output logic      [P0_PINS-1:0] p0_pu_weak_o,
    output logic      [P0_PINS-1:0] p0_pu_strong_o,
    output logic      [P0_PINS-1:0] p0_pd_o,
    output logic      [P1_PINS-1:0] p1_pu_vweak_o,
    output logic      [P1_PINS-1:0] p1_pu_weak_o,
    output logic      [P1_PINS-1:0] p1_pu_strong_o,
    output logic      [P1_PINS-1:0] p1_pd_o
);
    localparam int NPIN = P0_PINS + P1_PINS;

    logic [3:0] p0_latch_q;
    logic [3:0] p0_cfg_a_q;
    logic [3:0] p0_cfg_b_q;
    logic [7:0] p1_latch_q;
    logic [7:0] p1_cfg_a_q;
    logic [7:0] p1_cfg_b_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [P0_PINS-1:0] p0_sync;
    logic [P1_PINS-1:0] p1_sync;

    // fixed pin counts; the register widths depend on them
    initial begin
        if (P0_PINS != 4 || P1_PINS != 8) begin
            $error("cio_port supports only four and eight pins");
        end
    end

    // write strobe decode, shared by all registers
    function automatic logic wr_hit(input logic [7:0] a,
                                    input logic [7:0] want);
        return a == want;
    endfunction

    wire we_p0   = sfr_wr_i & wr_hit(sfr_addr_i, `CIO_ADDR_P0_LATCH);
    wire we_p1   = sfr_wr_i & wr_hit(sfr_addr_i, `CIO_ADDR_P1_LATCH);
    wire we_p1a  = sfr_wr_i & wr_hit(sfr_addr_i, `CIO_ADDR_P1_CFG_A);
    wire we_p1b  = sfr_wr_i & wr_hit(sfr_addr_i, `CIO_ADDR_P1_CFG_B);
    wire we_p0a  = sfr_wr_i & wr_hit(sfr_addr_i, `CIO_ADDR_P0_CFG_A);
    wire we_p0b  = sfr_wr_i & wr_hit(sfr_addr_i, `CIO_ADDR_P0_CFG_B);

    // port 0 registers, reserved bits not stored
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            p0_latch_q <= `CIO_RST_P0_LATCH;
            p0_cfg_a_q <= `CIO_RST_CFG4;
            p0_cfg_b_q <= `CIO_RST_CFG4;
        end else begin
            if (we_p0)  p0_latch_q <= sfr_wdata_i[3:0];
            if (we_p0a) p0_cfg_a_q <= sfr_wdata_i[3:0];
            if (we_p0b) p0_cfg_b_q <= sfr_wdata_i[3:0];
        end
    end

    // port 1 registers, cpu writes only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            p1_latch_q <= `CIO_RST_P1_LATCH;
            p1_cfg_a_q <= `CIO_RST_CFG8;
            p1_cfg_b_q <= `CIO_RST_CFG8;
        end else begin
            if (we_p1)  p1_latch_q <= sfr_wdata_i;
            if (we_p1a) p1_cfg_a_q <= sfr_wdata_i;
            if (we_p1b) p1_cfg_b_q <= sfr_wdata_i;
        end
    end

    // pins pass two flops before anything reads them
    cio_sync #(.WIDTH(P0_PINS)) u_sync0 (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (p0_pin_i),
        .sync_o  (p0_sync)
    );
    cio_sync #(.WIDTH(P1_PINS)) u_sync1 (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (p1_pin_i),
        .sync_o  (p1_sync)
    );

    // flatten both ports so one generate loop serves all pins
    wire [NPIN-1:0] all_latch = {p1_latch_q, p0_latch_q};
    wire [NPIN-1:0] all_sel_a = {p1_cfg_a_q, p0_cfg_a_q};
    wire [NPIN-1:0] all_sel_b = {p1_cfg_b_q, p0_cfg_b_q};
    wire [NPIN-1:0] all_sync  = {p1_sync, p0_sync};
    logic [NPIN-1:0] all_vw;
    logic [NPIN-1:0] all_wk;
    logic [NPIN-1:0] all_st;
    logic [NPIN-1:0] all_pd;

    // one pin cell per pin, each with its own mode bits
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        cio_pin u_pin (
            .mclk_i      (mclk_i),
            .rst_i       (rst_i),
            .latch_i     (all_latch[i]),
            .sel_a_i     (all_sel_a[i]),
            .sel_b_i     (all_sel_b[i]),
            .pin_sync_i  (all_sync[i]),
            .pu_vweak_o  (all_vw[i]),
            .pu_weak_o   (all_wk[i]),
            .pu_strong_o (all_st[i]),
            .pd_o        (all_pd[i])
        );
    end

    assign p0_pu_vweak_o  = all_vw[P0_PINS-1:0];
    assign p0_pu_weak_o   = all_wk[P0_PINS-1:0];
    assign p0_pu_strong_o = all_st[P0_PINS-1:0];
    assign p0_pd_o        = all_pd[P0_PINS-1:0];
    assign p1_pu_vweak_o  = all_vw[NPIN-1:P0_PINS];
    assign p1_pu_weak_o   = all_wk[NPIN-1:P0_PINS];
    assign p1_pu_strong_o = all_st[NPIN-1:P0_PINS];
    assign p1_pd_o        = all_pd[NPIN-1:P0_PINS];

    // latch addresses read the pin, not the latch
    always_comb begin
        rdata_d = 8'h00;
        case (sfr_addr_i)
            `CIO_ADDR_P0_LATCH: rdata_d = {`CIO_P0_RSVD_RD, p0_sync};
            `CIO_ADDR_P1_LATCH: rdata_d = p1_sync;
            `CIO_ADDR_P1_CFG_A: rdata_d = p1_cfg_a_q;
            `CIO_ADDR_P1_CFG_B: rdata_d = p1_cfg_b_q;
            `CIO_ADDR_P0_CFG_A: rdata_d = {`CIO_CFG_RSVD_RD, p0_cfg_a_q};
            `CIO_ADDR_P0_CFG_B: rdata_d = {`CIO_CFG_RSVD_RD, p0_cfg_b_q};
            default:            rdata_d = 8'h00;
        endcase
    end

    // read data registered; held between reads
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign sfr_hit_o = (sfr_addr_i == `CIO_ADDR_P0_LATCH)
                     | (sfr_addr_i == `CIO_ADDR_P1_LATCH)
                     | (sfr_addr_i >= `CIO_ADDR_P1_CFG_A
                        && sfr_addr_i <= `CIO_ADDR_P0_CFG_B);

    // per-pin mode masks, read only by the checks below
    wire [NPIN-1:0] m_quasi = ~all_sel_a & ~all_sel_b;
    wire [NPIN-1:0] m_push  = ~all_sel_a &  all_sel_b;
    wire [NPIN-1:0] m_input =  all_sel_a & ~all_sel_b;
    wire [NPIN-1:0] m_open  =  all_sel_a &  all_sel_b;

    // port 1 latch holds without a write
    a_p1_hold: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !we_p1 |=> $stable(p1_latch_q))
        else $error("port 1 latch changed without write");

    // port 0 latch takes low nibble
    a_p0_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        we_p0 |=> p0_latch_q == $past(sfr_wdata_i[3:0]))
        else $error("port 0 latch write lost");

    a_p1b_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        we_p1b |=> p1_cfg_b_q == $past(sfr_wdata_i))
        else $error("port 1 config b write lost");

    a_p1a_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        we_p1a |=> p1_cfg_a_q == $past(sfr_wdata_i))
        else $error("port 1 config a write lost");

    a_p0_rsvd: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == `CIO_ADDR_P0_CFG_A
        |=> sfr_rdata_o[7:4] == 4'h0)
        else $error("reserved mode bits not zero");

    a_input_off: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ((all_vw | all_wk | all_st | all_pd) & m_input)
        == '0)
        else $error("input-only pin driven");

    // open drain pulls only down, on zero
    a_open_drain: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ((all_vw | all_wk | all_st) & m_open) == '0
        && (all_pd & m_open) == (~all_latch & m_open))
        else $error("open drain pulls wrong");

    a_push_pull: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !p1_cfg_a_q[2] && p1_cfg_b_q[2] && p1_latch_q[2]
        |-> p1_pu_strong_o[2] && !p1_pd_o[2])
        else $error("push-pull strong pull-up missing");

    a_weak_pin: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        !p1_cfg_a_q[3] && !p1_cfg_b_q[3] && p1_latch_q[3]
        |-> p1_pu_weak_o[3] == p1_sync[3] && p1_pu_vweak_o[3])
        else $error("weak pull-up wrong");

    a_p1_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        we_p1
        |=> p1_latch_q == $past(sfr_wdata_i))
        else $error("port 1 latch write lost");

    a_p0a_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        we_p0a
        |=> p0_cfg_a_q == $past(sfr_wdata_i[3:0]))
        else $error("port 0 config a write lost");

    a_p0b_write: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        we_p0b
        |=> p0_cfg_b_q == $past(sfr_wdata_i[3:0]))
        else $error("port 0 config b write lost");

    a_rd_p1pin: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == `CIO_ADDR_P1_LATCH
        |=> sfr_rdata_o == $past(p1_sync))
        else $error("port 1 read not pin level");

    a_rd_p0pin: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == `CIO_ADDR_P0_LATCH
        |=> sfr_rdata_o == {`CIO_P0_RSVD_RD, $past(p0_sync)})
        else $error("port 0 read wrong");

    a_rd_cfg_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == `CIO_ADDR_P1_CFG_A
        |=> sfr_rdata_o == $past(p1_cfg_a_q))
        else $error("port 1 config a read wrong");

    a_rd_cfg_b: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == `CIO_ADDR_P1_CFG_B
        |=> sfr_rdata_o == $past(p1_cfg_b_q))
        else $error("port 1 config b read wrong");

    a_quasi_vweak: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (all_vw & m_quasi)
        == (all_latch & m_quasi))
        else $error("very weak pull-up wrong");

    a_quasi_low: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (all_pd & (m_quasi | m_push))
        == (~all_latch & (m_quasi | m_push)))
        else $error("quasi or push pull-down wrong");

    // port 1 mode writes leave port 0
    a_cfg_indep: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        we_p1a || we_p1b
        |=> $stable(p0_cfg_a_q) && $stable(p0_cfg_b_q))
        else $error("port 0 mode changed by port 1 write");

    // weak pull-up on every quasi pin with latch one and pin high
    a_weak_all: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (all_wk & m_quasi)
        == (all_latch & all_sync & m_quasi))
        else $error("weak pull-up wrong on a quasi pin");
endmodule

// ==== tb/cio_pins_model.sv ====
// behavioural pins and outside circuitry for the io port block
`timescale 1ns/1ps
module cio_pins_model (
    input  wire logic        mclk_i,
    input  wire logic [11:0] pu_i,
    input  wire logic [11:0] pd_i,
    input  wire logic [11:0] ext_en_i,
    input  wire logic [11:0] ext_val_i,
    input  wire logic [11:0] ext_pu_i,
    output logic      [11:0] pin_o
);
    logic tog_q = 1'b0;

    // a floating pin wanders each cycle, so no level is ever assumed
    always @(posedge mclk_i) begin
        tog_q <= ~tog_q;
    end

    // outside pull-up resistor
    // pull-down wins, then outside drive, then any pull-up or resistor
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (pd_i[i])
                pin_o[i] = 1'b0;
            else if (ext_en_i[i])
                pin_o[i] = ext_val_i[i];
            else if (pu_i[i] | ext_pu_i[i])
                pin_o[i] = 1'b1;
            else
                pin_o[i] = tog_q;
        end
    end
endmodule

// ==== tb/cio_port_bench.sv ====
// self-checking bench for the io port block
`timescale 1ns/1ps
`include "cio_defs.svh"
module cio_port_bench;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_rdata;
    logic        sfr_hit;
    logic [3:0]  p0_v, p0_w, p0_s, p0_d;
    logic [7:0]  p1_v, p1_w, p1_s, p1_d;
    logic [11:0] ext_en = 12'h000;
    logic [11:0] ext_val = 12'h000;
    // resistor on port 1 pin 2 for open drain
    logic [11:0] ext_pu = 12'h040;
    logic [11:0] pins;
    int          errors = 0;
    int          checks = 0;
    // {vweak, weak, strong, down} per mode and latch value
    logic [3:0]  mode_exp [8] = '{4'h1, 4'hc, 4'h1, 4'h2,
                                  4'h0, 4'h0, 4'h1, 4'h0};

    // 20 MHz system clock
    always #25 mclk_i = ~mclk_i;

    cio_port DUT (
        .mclk_i         (mclk_i),
        .rst_i          (rst_i),
        .sfr_addr_i     (sfr_addr),
        .sfr_wdata_i    (sfr_wdata),
        .sfr_wr_i       (sfr_wr),
        .sfr_rd_i       (sfr_rd),
        .sfr_rdata_o    (sfr_rdata),
        .sfr_hit_o      (sfr_hit),
        .p0_pin_i       (pins[3:0]),
        .p1_pin_i       (pins[11:4]),
        .p0_pu_vweak_o  (p0_v),
        .p0_pu_weak_o   (p0_w),
        .p0_pu_strong_o (p0_s),
        .p0_pd_o        (p0_d),
        .p1_pu_vweak_o  (p1_v),
        .p1_pu_weak_o   (p1_w),
        .p1_pu_strong_o (p1_s),
        .p1_pd_o        (p1_d)
    );

    cio_pins_model PINS (
        .mclk_i    (mclk_i),
        .pu_i      ({p1_v | p1_w | p1_s, p0_v | p0_w | p0_s}),
        .pd_i      ({p1_d, p0_d}),
        .ext_en_i  (ext_en),
        .ext_val_i (ext_val),
        .ext_pu_i  (ext_pu),
        .pin_o     (pins)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // one-cycle write strobe, register loads at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge mclk_i);
        sfr_wr <= 1'b0;
        #1;
    endtask

    // read data lands on the edge that samples the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge mclk_i);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata, exp);
    endtask

    task automatic give_verdict();
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 134 cycles the tests need
    initial begin
        repeat (4000) @(posedge mclk_i);
        errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        cyc(3);
        chk(p1_v, 8'hff);
        chk({4'h0, p0_v}, 8'h0f);
        chk({4'h0, p0_w}, 8'h0f);
        chk(p1_w, 8'hff);
        chk(p1_s | p1_d, 8'h00);
        rd(`CIO_ADDR_P0_LATCH, 8'hff);
        rd(`CIO_ADDR_P1_CFG_A, 8'h00);
        rd(`CIO_ADDR_P1_CFG_B, 8'h00);
        rd(`CIO_ADDR_P0_CFG_A, 8'h00);
        rd(`CIO_ADDR_P0_CFG_B, 8'h00);
        rd(8'h95, 8'h00);
        chk({7'h0, sfr_hit}, 8'h00);
        wr(`CIO_ADDR_P1_CFG_B, 8'h5a);
        rd(`CIO_ADDR_P1_CFG_B, 8'h5a);
        chk({7'h0, sfr_hit}, 8'h01);
        wr(`CIO_ADDR_P1_CFG_B, 8'h00);
        wr(`CIO_ADDR_P0_CFG_A, 8'h0f);
        rd(`CIO_ADDR_P0_CFG_A, 8'h0f);
        wr(`CIO_ADDR_P0_CFG_A, 8'h00);
        // quasi low drive, then a rise gives a two-cycle boost
        wr(`CIO_ADDR_P1_LATCH, 8'h00);
        chk(p1_d, 8'hff);
        chk(p1_v | p1_w, 8'h00);
        // boost counter loads on the rise, so it shows one cycle later
        wr(`CIO_ADDR_P1_LATCH, 8'h01);
        cyc(1);
        chk(p1_s, 8'h01);
        cyc(1);
        chk(p1_s, 8'h01);
        cyc(1);
        chk(p1_s, 8'h00);
        wr(`CIO_ADDR_P1_LATCH, 8'hff);
        cyc(3);
        // outside device sinks port 1 pin 1
        @(posedge mclk_i);
        ext_en <= 12'h020;
        cyc(3);
        chk(p1_w, 8'hfd);
        chk(p1_v, 8'hff);
        rd(`CIO_ADDR_P1_LATCH, 8'hfd);
        @(posedge mclk_i);
        ext_en <= 12'h000;
        cyc(3);
        chk(p1_w, 8'hff);
        // every mode on port 1 pin 2 with both latch values
        for (int m = 0; m < 4; m++) begin
            wr(`CIO_ADDR_P1_CFG_A, {5'h0, m[1], 2'h0});
            wr(`CIO_ADDR_P1_CFG_B, {5'h0, m[0], 2'h0});
            for (int l = 0; l < 2; l++) begin
                wr(`CIO_ADDR_P1_LATCH, (l == 1) ? 8'hff : 8'hfb);
                cyc(3);
                chk({4'h0, p1_v[2], p1_w[2], p1_s[2], p1_d[2]},
                    {4'h0, mode_exp[m * 2 + l]});
            end
        end
        wr(`CIO_ADDR_P1_CFG_A, 8'h00);
        wr(`CIO_ADDR_P1_CFG_B, 8'h00);
        // port 0 pin 3 push-pull, other pins untouched
        wr(`CIO_ADDR_P0_CFG_B, 8'h08);
        cyc(3);
        chk({4'h0, p0_s}, 8'h08);
        chk(p1_s, 8'h00);
        wr(`CIO_ADDR_P0_LATCH, 8'hf5);
        cyc(3);
        chk({4'h0, p0_d}, 8'h0a);
        rd(`CIO_ADDR_P0_LATCH, 8'hf5);
        // a mid-run reset must restore port 1 config a, port 0 config b and port 0 latch defaults
        wr(`CIO_ADDR_P1_CFG_A, 8'h3c);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(`CIO_ADDR_P1_CFG_A, 8'h00);
        rd(`CIO_ADDR_P0_CFG_B, 8'h00);
        rd(`CIO_ADDR_P0_LATCH, 8'hff);
        give_verdict();
    end
endmodule
